// [rtl/eses_param_mem.sv]
// parameter store: one word per service number, registered read port
`timescale 1ns/1ps

module eses_param_mem #(
    parameter int AW = 6,
    parameter int DW = 24
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data_q
);

    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rd_data_d;

    // the array holds no reset: unwritten services read back as whatever is stored
    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_comb begin
        rd_data_d = rd_data_q;
        if (rd_en) begin
            rd_data_d = mem[rd_addr];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

endmodule

// [rtl/eses_pkg.sv]
// package: constants, register map and state type of the encoder service error-status block
package eses_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the axi4-lite slave)
    // ------------------------------------------------------------
    localparam int          ESES_REG_AW       = 8;
    localparam logic [7:0]  OFF_ERR_STAT      = 8'h00;
    localparam logic [7:0]  OFF_IRQ_STAT      = 8'h04;
    localparam logic [7:0]  OFF_IRQ_EN        = 8'h08;
    localparam logic [7:0]  OFF_IRQ_CLR       = 8'h0c;
    localparam logic [7:0]  OFF_CTRL          = 8'h10;
    localparam logic [7:0]  OFF_LAST_RESP     = 8'h14;
    localparam int          CTRL_CLR_ON_CHECK = 0;

    localparam logic [1:0]  AXI_OKAY          = 2'h0;
    localparam logic [1:0]  AXI_DECERR        = 2'h3;

    // ------------------------------------------------------------
    // error status layout
    // ------------------------------------------------------------
    localparam int          ERR_W             = 16;
    localparam int          ERR_NVM_RD        = 0;
    localparam int          ERR_NVM_WR        = 1;
    localparam int          ERR_RD_ONLY       = 2;
    localparam int          ERR_WR_ONLY       = 3;
    localparam int          ERR_UNKNOWN       = 7;
    localparam int          ERR_NUM_ZERO      = 13;
    localparam int          ERR_STEPS_HIGH    = 14;
    localparam logic [15:0] ERR_USED_MASK     = 16'h608f;

    // ------------------------------------------------------------
    // service request word
    // ------------------------------------------------------------
    localparam int          REQ_RW_BIT        = 30;
    localparam int          REQ_SVC_LSB       = 24;
    localparam int          SVC_W             = 6;
    localparam int          DATA_W            = 24;
    localparam int          NUM_W             = 16;
    localparam int          DEN_W             = 7;

    localparam logic [5:0]  SVC_MEAS_LEN      = 6'h02;
    localparam logic [5:0]  SVC_REV_NUM       = 6'h03;
    localparam logic [5:0]  SVC_PRESET        = 6'h06;
    localparam logic [5:0]  SVC_CHECK         = 6'h08;
    localparam logic [5:0]  SVC_REV_DEN       = 6'h09;
    localparam logic [5:0]  SVC_SSI           = 6'h0d;

    localparam logic [23:0] RESOLUTION_DEF    = 24'h002000;

    // ------------------------------------------------------------
    // state of the top module
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_RDWAIT
    } eses_fsm_t;

    typedef struct packed {
        eses_fsm_t          fsm;
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               aw_held;
        logic               w_held;
        logic [7:0]         awaddr;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        logic               arready;
        logic               rvalid;
        logic [1:0]         rresp;
        logic [31:0]        rdata;
        logic [15:0]        err;
        logic [15:0]        irq_stat;
        logic [15:0]        irq_en;
        logic               clr_on_check;
        logic               irq;
        logic               req_ready;
        logic               resp_valid;
        logic [31:0]        resp_word;
        logic [7:0]         pend_svc;
        logic [23:0]        meas_len;
        logic [15:0]        numer;
        logic [6:0]         denom;
    } eses_regs_t;

    localparam eses_regs_t  ESES_REGS_RST     = '0;

endpackage

// [rtl/eses_top.sv]
// service request handling, error status, interrupt and axi4-lite register slave
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

module eses_top
    import eses_pkg::*;
#(
    parameter logic [23:0] RESOLUTION = RESOLUTION_DEF
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        req_valid,
    input  wire logic [31:0] req_word,
    output logic             req_ready,
    output logic             resp_valid,
    output logic [31:0]      resp_word,
    input  wire logic        nvm_rd_fail,
    input  wire logic        nvm_wr_fail,
    output logic             irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // {can_read, can_write}; 2'b00 marks an unsupported service
    function automatic logic [1:0] svc_access(input logic [5:0] svc);
        logic [1:0] acc;
        acc = 2'b00;
        case (svc)
            SVC_MEAS_LEN, SVC_REV_NUM, SVC_REV_DEN, SVC_SSI: acc = 2'b11;
            SVC_PRESET: acc = 2'b01;
            SVC_CHECK:  acc = 2'b10;
            default:    acc = 2'b00;
        endcase
        return acc;
    endfunction

    // meas/(num/den) > res rewritten as meas*den > res*num to avoid a divider
    function automatic logic steps_exceed(input logic [23:0] meas, input logic [6:0] den,
                                          input logic [15:0] num, input logic [23:0] res);
        logic [39:0] lhs;
        logic [39:0] rhs;
        lhs = 40'(meas) * 40'(den);
        rhs = 40'(res) * 40'(num);
        return lhs > rhs;
    endfunction

    function automatic logic [31:0] apply_strobe(input logic [31:0] old_v,
                                                 input logic [31:0] new_v,
                                                 input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    eses_regs_t         s_q;
    eses_regs_t         s_d;
    logic [5:0]         svc;
    logic               req_rw;
    logic [23:0]        req_data;
    logic [1:0]         acc;
    logic               take;
    logic [15:0]        set;
    logic               clr_err;
    logic [15:0]        irq_clr;
    logic [31:0]        wr_val;
    logic               mem_we;
    logic               mem_re;
    logic [23:0]        mem_rd;
    logic               num_zero;
    logic               too_high;

    assign svc      = req_word[REQ_SVC_LSB +: SVC_W];
    assign req_rw   = req_word[REQ_RW_BIT];
    assign req_data = req_word[DATA_W-1:0];
    assign acc      = svc_access(svc);
    assign take     = req_valid && s_q.req_ready;
    assign num_zero = (s_q.numer == '0);
    assign too_high = !num_zero && steps_exceed(s_q.meas_len, s_q.denom, s_q.numer, RESOLUTION);

    eses_param_mem #(
        .AW (SVC_W),
        .DW (DATA_W)
    ) u_mem (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .wr_en     (mem_we),
        .wr_addr   (svc),
        .wr_data   (req_data),
        .rd_en     (mem_re),
        .rd_addr   (svc),
        .rd_data_q (mem_rd)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d            = s_q;
        s_d.resp_valid = 1'b0;
        set            = '0;
        clr_err        = 1'b0;
        irq_clr        = '0;
        wr_val         = '0;
        mem_we         = 1'b0;
        mem_re         = 1'b0;

        set[ERR_NVM_RD] = nvm_rd_fail;
        set[ERR_NVM_WR] = nvm_wr_fail;

        case (s_q.fsm)
            ST_IDLE: begin
                if (take) begin
                    s_d.pend_svc  = req_word[31:24];
                    s_d.resp_word = req_word;
                    if (acc == 2'b00) begin
                        set[ERR_UNKNOWN] = 1'b1;
                        s_d.resp_valid   = 1'b1;
                    end else if (req_rw && !acc[0]) begin
                        set[ERR_RD_ONLY] = 1'b1;
                        s_d.resp_valid   = 1'b1;
                    end else if (!req_rw && !acc[1]) begin
                        set[ERR_WR_ONLY] = 1'b1;
                        s_d.resp_valid   = 1'b1;
                    end else if (req_rw) begin
                        mem_we         = 1'b1;
                        s_d.resp_valid = 1'b1;
                        if (svc == SVC_MEAS_LEN) begin
                            s_d.meas_len = req_data;
                        end
                        if (svc == SVC_REV_NUM) begin
                            s_d.numer = req_data[NUM_W-1:0];
                            set[ERR_NUM_ZERO] = (req_data[NUM_W-1:0] == '0);
                        end
                        if (svc == SVC_REV_DEN) begin
                            s_d.denom = req_data[DEN_W-1:0];
                        end
                    end else if (svc == SVC_CHECK) begin
                        set[ERR_NUM_ZERO]   = num_zero;
                        set[ERR_STEPS_HIGH] = too_high;
                        s_d.resp_valid      = 1'b1;
                        s_d.resp_word       = {req_word[31:24], 8'h00,
                                               s_q.err | set};
                        clr_err             = s_q.clr_on_check;
                    end else begin
                        mem_re  = 1'b1;
                        s_d.fsm = ST_RDWAIT;
                    end
                end
            end
            ST_RDWAIT: begin
                s_d.resp_valid = 1'b1;
                s_d.resp_word  = {s_q.pend_svc, mem_rd};
                s_d.fsm        = ST_IDLE;
            end
            default: begin
                s_d.fsm = ST_IDLE;
            end
        endcase

        // ------------------------------------------------------------
        // axi4-lite write channel: address and data taken in either order
        // ------------------------------------------------------------
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.awready && s_axi_awvalid) begin
            s_d.aw_held = 1'b1;
            s_d.awaddr  = s_axi_awaddr;
        end
        if (s_q.wready && s_axi_wvalid) begin
            s_d.w_held = 1'b1;
            s_d.wdata  = s_axi_wdata;
            s_d.wstrb  = s_axi_wstrb;
        end
        if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = AXI_OKAY;
            case (s_q.awaddr)
                OFF_IRQ_EN: begin
                    wr_val     = apply_strobe({16'h0000, s_q.irq_en}, s_q.wdata, s_q.wstrb);
                    s_d.irq_en = wr_val[15:0];
                end
                OFF_IRQ_CLR: begin
                    wr_val  = apply_strobe(32'h0000_0000, s_q.wdata, s_q.wstrb);
                    irq_clr = wr_val[15:0];
                end
                OFF_CTRL: begin
                    wr_val           = apply_strobe({31'h0000_0000, s_q.clr_on_check},
                                                    s_q.wdata, s_q.wstrb);
                    s_d.clr_on_check = wr_val[CTRL_CLR_ON_CHECK];
                end
                OFF_ERR_STAT, OFF_IRQ_STAT, OFF_LAST_RESP: begin
                    s_d.bresp = AXI_OKAY;
                end
                default: begin
                    s_d.bresp = AXI_DECERR;
                end
            endcase
        end
        s_d.awready = !s_d.aw_held && !s_d.bvalid;
        s_d.wready  = !s_d.w_held && !s_d.bvalid;

        // ------------------------------------------------------------
        // axi4-lite read channel
        // ------------------------------------------------------------
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_q.arready && s_axi_arvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = AXI_OKAY;
            case (s_axi_araddr)
                OFF_ERR_STAT:  s_d.rdata = {16'h0000, s_q.err};
                OFF_IRQ_STAT:  s_d.rdata = {16'h0000, s_q.irq_stat};
                OFF_IRQ_EN:    s_d.rdata = {16'h0000, s_q.irq_en};
                OFF_IRQ_CLR:   s_d.rdata = 32'h0000_0000;
                OFF_CTRL:      s_d.rdata = {31'h0000_0000, s_q.clr_on_check};
                OFF_LAST_RESP: s_d.rdata = s_q.resp_word;
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = AXI_DECERR;
                end
            endcase
        end
        s_d.arready = !s_d.rvalid;

        // ------------------------------------------------------------
        // error status and interrupt: a new event wins over any clear
        // ------------------------------------------------------------
        s_d.err       = (set & ERR_USED_MASK) | (clr_err ? 16'h0000 : s_q.err);
        s_d.irq_stat  = (set & ERR_USED_MASK) | (s_q.irq_stat & ~irq_clr);
        s_d.irq       = |(s_d.irq_stat & s_d.irq_en);
        s_d.req_ready = (s_d.fsm == ST_IDLE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= ESES_REGS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign req_ready     = s_q.req_ready;
    assign resp_valid    = s_q.resp_valid;
    assign resp_word     = s_q.resp_word;
    assign irq           = s_q.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    nvm_rd_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        nvm_rd_fail |=> s_q.err[ERR_NVM_RD] && s_q.irq_stat[ERR_NVM_RD])
        else $error("nvm read failure not flagged");

    nvm_wr_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        nvm_wr_fail |=> s_q.err[ERR_NVM_WR])
        else $error("nvm write failure not flagged");

    read_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
        take && req_rw && svc_access(svc) == 2'b10 |=> s_q.err[ERR_RD_ONLY] && resp_valid)
        else $error("write on read-only service not flagged");

    write_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
        take && !req_rw && svc_access(svc) == 2'b01 |=> s_q.err[ERR_WR_ONLY] && resp_valid)
        else $error("read on write-only service not flagged");

    unknown_svc_a: assert property (@(posedge aclk) disable iff (!aresetn)
        take && svc_access(svc) == 2'b00 |=> s_q.err[ERR_UNKNOWN]
                                          && $past(req_word) == resp_word)
        else $error("unknown service not flagged");

    num_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (take && req_rw && svc == SVC_REV_NUM && req_data[NUM_W-1:0] == 16'h0000)
        || (take && !req_rw && svc == SVC_CHECK && num_zero) |=> s_q.err[ERR_NUM_ZERO])
        else $error("zero numerator not flagged");

    steps_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
        take && !req_rw && svc == SVC_CHECK && too_high |=> s_q.err[ERR_STEPS_HIGH])
        else $error("steps per revolution overflow not flagged");

    check_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        take && !req_rw && svc == SVC_CHECK |=> resp_valid && resp_word[23:16] == 8'h00
            && resp_word[31:24] == $past(req_word[31:24])
            && (resp_word[15:0] & ~ERR_USED_MASK) == 16'h0000)
        else $error("data check answer malformed");

    read_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
        take && !req_rw && svc_access(svc) == 2'b11 |=> !resp_valid && !req_ready ##1
            resp_valid && req_ready && resp_word[31:24] == $past(req_word[31:24], 2))
        else $error("parameter read answer not two cycles after request");

endmodule

// [sim/eses_master_model.sv]
// partner model: fieldbus master that issues service requests
`timescale 1ns/1ps
module eses_master_model (
    input  wire logic        aclk,
    input  wire logic        req_ready,
    input  wire logic        resp_valid,
    input  wire logic [31:0] resp_word,
    output logic             req_valid,
    output logic [31:0]      req_word
);
    int fails = 0;
    int gap   = 0;
    initial begin
        req_valid = 1'b0;
        req_word  = 32'h0;
    end
    // bit 30 picks write, [29:24] the service, [23:0] the data
    task automatic send(input logic [31:0] w, output logic [31:0] r);
        int n;
        n = 0;
        repeat (gap) @(posedge aclk);
        req_valid <= 1'b1;
        req_word  <= w;
        do begin
            @(posedge aclk);
            n++;
        end while (!req_ready && n < 40);
        req_valid <= 1'b0;
        // a released word shows its inverse, so a stale value is never mistaken
        req_word  <= ~w;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!resp_valid && n < 40);
        r = resp_word;
        if (n >= 40) fails++;
    endtask
endmodule

// [sim/eses_tb_top.sv]
// testbench: register access and service requests against the error-status block
`timescale 1ns/1ps
module eses_tb_top import eses_pkg::*; ;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, req_word, resp_word;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        req_valid, req_ready, resp_valid, nvm_rd_fail, nvm_wr_fail, irq;
    int          bad_count = 0;
    int          cmp_count = 0;

    eses_top #(.RESOLUTION(RESOLUTION_DEF)) i_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req_word, .req_ready,
        .resp_valid, .resp_word, .nvm_rd_fail, .nvm_wr_fail, .irq
    );
    eses_master_model i_master (
        .aclk, .req_ready, .resp_valid, .resp_word, .req_valid, .req_word
    );

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic give_up;
        bad_count++;
        $display("mismatch wait expected answer seen none");
        final_report();
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        // bready stays high between calls; each write still drives it high again before waiting for bvalid
        if (n >= 40) give_up();
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        if (n >= 40) give_up();
        check("rdata", s_axi_rdata, exp);
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task automatic svc(input logic [31:0] w, input logic [31:0] exp);
        logic [31:0] got;
        i_master.send(w, got);
        if (i_master.fails != 0) give_up();
        check("feedback", got, exp);
    endtask

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, nvm_rd_fail, nvm_wr_fail, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (4) @(posedge aclk);
        aresetn      <= 1'b1;
        s_axi_bready <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        axi_rd(OFF_ERR_STAT, 32'h0, AXI_OKAY);
        axi_rd(OFF_IRQ_EN, 32'h0, AXI_OKAY);
        axi_rd(8'h18, 32'h0, AXI_DECERR);
        axi_wr(8'h18, 32'h1, AXI_DECERR);
        axi_wr(OFF_CTRL, 32'h1, AXI_OKAY);
        axi_rd(OFF_CTRL, 32'h1, AXI_OKAY);
        axi_wr(OFF_CTRL, 32'h0, AXI_OKAY);
        // steps exactly at the native resolution must pass the data check
        svc({8'hc2, RESOLUTION_DEF}, {8'hc2, RESOLUTION_DEF});
        svc(32'hc3000001, 32'hc3000001);
        i_master.gap = 3;
        svc(32'hc9000001, 32'hc9000001);
        i_master.gap = 0;
        svc(32'h83000000, 32'h83000001);
        svc(32'h88000000, 32'h88000000);
        svc({8'hc2, RESOLUTION_DEF + 24'h1}, {8'hc2, RESOLUTION_DEF + 24'h1});
        svc(32'h88000000, 32'h88004000);
        svc(32'h81123456, 32'h81123456);
        svc(32'hc8000000, 32'hc8000000);
        svc(32'h86000000, 32'h86000000);
        nvm_rd_fail <= 1'b1;
        @(posedge aclk);
        nvm_rd_fail <= 1'b0;
        nvm_wr_fail <= 1'b1;
        @(posedge aclk);
        nvm_wr_fail <= 1'b0;
        @(posedge aclk);
        svc(32'hc3000000, 32'hc3000000);
        axi_rd(OFF_ERR_STAT, 32'h0000608f, AXI_OKAY);
        check("irq masked", {31'h0, irq}, 32'h0);
        svc(32'h88000000, 32'h8800608f);
        axi_wr(OFF_ERR_STAT, 32'h0, AXI_OKAY);
        axi_rd(OFF_ERR_STAT, 32'h0000608f, AXI_OKAY);
        axi_wr(OFF_IRQ_EN, 32'h00000080, AXI_OKAY);
        axi_rd(OFF_IRQ_EN, 32'h00000080, AXI_OKAY);
        check("irq on", {31'h0, irq}, 32'h1);
        axi_rd(OFF_IRQ_STAT, 32'h0000608f, AXI_OKAY);
        axi_wr(OFF_IRQ_CLR, 32'h00000080, AXI_OKAY);
        axi_rd(OFF_IRQ_CLR, 32'h0, AXI_OKAY);
        check("irq off", {31'h0, irq}, 32'h0);
        axi_rd(OFF_IRQ_STAT, 32'h0000600f, AXI_OKAY);
        axi_rd(OFF_LAST_RESP, 32'h8800608f, AXI_OKAY);
        // clear-on-check: the check reports the old status, then only its own new bits remain
        axi_wr(OFF_CTRL, 32'h1, AXI_OKAY);
        svc(32'h88000000, 32'h8800608f);
        axi_rd(OFF_ERR_STAT, 32'h00002000, AXI_OKAY);
        axi_rd(OFF_IRQ_STAT, 32'h0000600f, AXI_OKAY);
        final_report();
    end
endmodule
